// file: rtl/addr_map_regs.sv
/*
 * Address-mapping register bank of the host-to-pci bridge: inbound window
 * base/mask/translated base, upper address extensions, latency preload with the
 * master latency timer, and the translation entry store with flush.
 * Assumes the register port, entry fill and lookup inputs come from logic on clk.
 */
// The implementer's own choices: the address-and-strobe port and the register addresses.
//
// Overview of operation
// - window mask field in bits 31:20
// - first extension register reads zero, ignores writes
// - memory cycles take AD 31:27 from register
// - io cycles take AD 31:24 from register
// - config cycles take AD 1:0 from register
// - latency timer preloaded at each master start
// - tag registers show pci page bits 31:13
// - tag bit 12 shows entry valid, resets zero
// - data registers bits 20:1 show cpu page
// - any write to flush invalidates every entry except one filled in the same cycle
// - window base field bits 31:20 with mask
// - map table enable selects direct or table mapping
`timescale 1ns/1ps

module addr_map_regs #(
	parameter int unsigned ENTRIES = 8
) (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic [7:0]                  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [31:0]                      reg_rdata,
	output logic [4:0]                       upper_pci_addr_bits,
	output logic [7:0]                       io_upper_addr_bits,
	output logic [1:0]                       cfg_low_addr_bits,
	input  wire logic                        master_start,
	input  wire logic                        master_active,
	output logic [7:0]                       latency_count,
	output logic                             latency_expired,
	input  wire logic                        fill_req,
	input  wire logic [2:0]                  fill_index,
	input  wire addr_map_pkg::xlate_entry_t  fill_entry,
	input  wire logic                        lookup_req,
	input  wire logic [31:0]                 lookup_addr,
	output logic                             lookup_done,
	output addr_map_pkg::lookup_result_t     lookup_result
);

	initial
	begin
		if (ENTRIES != 8)
			$error("addr_map_regs: register map holds exactly eight entries");
	end

	logic [31:0]                  rdata_ff;
	logic [31:0]                  nxt_rdata;
	logic [4:0]                   mem_upper_ff;
	logic [7:0]                   io_upper_ff;
	logic [1:0]                   cfg_low_ff;
	logic [7:0]                   latency_timer_preload_ff;
	logic [7:0]                   lat_count_ff;
	logic                         lat_expired_ff;
	addr_map_pkg::window_t        win_ff [2];
	addr_map_pkg::xlate_entry_t   entry_ff [ENTRIES];
	logic [ENTRIES-1:0]           entry_match;
	logic                         flush_wr;
	logic                         lookup_done_ff;
	addr_map_pkg::lookup_result_t lookup_ff;
	addr_map_pkg::lookup_result_t nxt_lookup;

	assign reg_rdata           = rdata_ff;
	assign upper_pci_addr_bits = mem_upper_ff;
	assign io_upper_addr_bits  = io_upper_ff;
	assign cfg_low_addr_bits   = cfg_low_ff;
	assign latency_count       = lat_count_ff;
	assign latency_expired     = lat_expired_ff;
	assign lookup_done         = lookup_done_ff;
	assign lookup_result       = lookup_ff;

	// any data value triggers the flush; the offset alone matters
	assign flush_wr = reg_wr && (reg_addr == addr_map_pkg::OFS_FLUSH_ALL);

	// extension registers; the zero register has no storage at all
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mem_upper_ff <= addr_map_pkg::MEM_UPPER_RST;
			io_upper_ff  <= addr_map_pkg::IO_UPPER_RST;
			cfg_low_ff   <= addr_map_pkg::CFG_LOW_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == addr_map_pkg::OFS_MEM_UPPER)
				mem_upper_ff <= reg_wdata[addr_map_pkg::MEM_UPPER_LSB +: 5];
			if (reg_addr == addr_map_pkg::OFS_IO_CFG_EXT)
			begin
				io_upper_ff <= reg_wdata[addr_map_pkg::IO_UPPER_LSB +: 8];
				cfg_low_ff  <= reg_wdata[addr_map_pkg::CFG_LOW_LSB +: 2];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			latency_timer_preload_ff <= addr_map_pkg::PRELOAD_RST;
		else if (reg_wr && reg_addr == addr_map_pkg::OFS_LAT_PRELOAD)
			latency_timer_preload_ff <= reg_wdata[addr_map_pkg::PRELOAD_LSB +: 8];
	end

	// master latency timer; a zero preload expires at once, hence the advice to software
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			lat_count_ff   <= 8'h00;
			lat_expired_ff <= 1'b0;
		end
		else if (master_start)
		begin
			lat_count_ff   <= latency_timer_preload_ff;
			lat_expired_ff <= 1'b0;
		end
		else if (master_active)
		begin
			if (lat_count_ff != 8'h00)
				lat_count_ff <= lat_count_ff - 8'h01;
			lat_expired_ff <= (lat_count_ff <= 8'h01);
		end
		else
			lat_expired_ff <= 1'b0;
	end

	// inbound windows
	for (genvar w = 0; w < 2; w++)
	begin : g_win
		localparam logic [7:0] OFS_BASE  = (w == 0) ? addr_map_pkg::OFS_WIN_BASE_1
			: addr_map_pkg::OFS_WIN_BASE_2;
		localparam logic [7:0] OFS_MASK  = (w == 0) ? addr_map_pkg::OFS_WIN_MASK_1
			: addr_map_pkg::OFS_WIN_MASK_2;
		localparam logic [7:0] OFS_XLATE = (w == 0) ? addr_map_pkg::OFS_XLATE_BASE_1
			: addr_map_pkg::OFS_XLATE_BASE_2;

		always_ff @(posedge clk)
		begin
			if (!resetn)
			begin
				win_ff[w].base             <= addr_map_pkg::WIN_FIELD_RST;
				win_ff[w].mask             <= addr_map_pkg::WIN_FIELD_RST;
				win_ff[w].enable           <= 1'b0;
				win_ff[w].map_table_enable <= 1'b0;
				win_ff[w].xlate_base       <= addr_map_pkg::XLATE_BASE_RST;
			end
			else if (reg_wr)
			begin
				if (reg_addr == OFS_BASE)
				begin
					win_ff[w].base             <= reg_wdata[addr_map_pkg::WIN_FIELD_LSB +: 12];
					win_ff[w].enable           <= reg_wdata[addr_map_pkg::WIN_ENABLE_BIT];
					win_ff[w].map_table_enable <= reg_wdata[addr_map_pkg::MAP_TABLE_BIT];
				end
				if (reg_addr == OFS_MASK)
					win_ff[w].mask <= reg_wdata[addr_map_pkg::WIN_FIELD_LSB +: 12];
				if (reg_addr == OFS_XLATE)
					win_ff[w].xlate_base <= reg_wdata[addr_map_pkg::XLATE_BASE_LSB +: 23];
			end
		end
	end

	// translation entries; a fill in the flush cycle keeps its valid bit
	for (genvar e = 0; e < ENTRIES; e++)
	begin : g_entry
		always_ff @(posedge clk)
		begin
			if (!resetn)
			begin
				entry_ff[e].entry_valid_flag <= addr_map_pkg::ENTRY_VALID_RST;
				entry_ff[e].upper_pci_page   <= 19'h00000;
				entry_ff[e].cpu_page         <= 20'h00000;
			end
			else if (fill_req && fill_index == 3'(e))
				entry_ff[e] <= fill_entry;
			else if (flush_wr)
				entry_ff[e].entry_valid_flag <= 1'b0;
		end

		assign entry_match[e] = entry_ff[e].entry_valid_flag
			&& (entry_ff[e].upper_pci_page == lookup_addr[31:13]);
	end

	// register read: data stands one cycle after the strobe, zero otherwise
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (reg_addr[7:5] == addr_map_pkg::OFS_TAG_GROUP)
			nxt_rdata = {entry_ff[reg_addr[4:2]].upper_pci_page,
				entry_ff[reg_addr[4:2]].entry_valid_flag, 12'h000};
		else if (reg_addr[7:5] == addr_map_pkg::OFS_PAGE_GROUP)
			nxt_rdata = {11'h000, entry_ff[reg_addr[4:2]].cpu_page, 1'b0};
		else
		begin
			case (reg_addr)
				addr_map_pkg::OFS_WIN_BASE_1:
					nxt_rdata = {win_ff[0].base, win_ff[0].enable,
						win_ff[0].map_table_enable, 18'h00000};
				addr_map_pkg::OFS_WIN_MASK_1:
					nxt_rdata = {win_ff[0].mask, 20'h00000};
				addr_map_pkg::OFS_XLATE_BASE_1:
					nxt_rdata = {win_ff[0].xlate_base, 9'h000};
				addr_map_pkg::OFS_WIN_BASE_2:
					nxt_rdata = {win_ff[1].base, win_ff[1].enable,
						win_ff[1].map_table_enable, 18'h00000};
				addr_map_pkg::OFS_WIN_MASK_2:
					nxt_rdata = {win_ff[1].mask, 20'h00000};
				addr_map_pkg::OFS_XLATE_BASE_2:
					nxt_rdata = {win_ff[1].xlate_base, 9'h000};
				addr_map_pkg::OFS_EXT_ZERO:
					nxt_rdata = 32'h0000_0000;
				addr_map_pkg::OFS_MEM_UPPER:
					nxt_rdata = {mem_upper_ff, 27'h0000000};
				addr_map_pkg::OFS_IO_CFG_EXT:
					nxt_rdata = {io_upper_ff, 22'h000000, cfg_low_ff};
				addr_map_pkg::OFS_LAT_PRELOAD:
					nxt_rdata = {24'h000000, latency_timer_preload_ff};
				default:
					nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			rdata_ff <= 32'h0000_0000;
		else if (reg_rd)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= 32'h0000_0000;
	end

	// window lookup; the first window wins when both claim an address
	always_comb
	begin
		logic [32:0] mask_full;
		logic [32:0] base_full;
		logic [32:0] page_index;
		logic        sel;
		logic [1:0]  win_hit;

		mask_full  = 33'h000000000;
		base_full  = 33'h000000000;
		page_index = 33'h000000000;
		sel        = 1'b0;
		win_hit    = 2'b00;
		nxt_lookup = '0;
		for (int w = 0; w < 2; w++)
			win_hit[w] = win_ff[w].enable && ((lookup_addr[31:20] & ~win_ff[w].mask)
				== (win_ff[w].base & ~win_ff[w].mask));
		sel        = !win_hit[0];
		mask_full  = {1'b0, win_ff[sel].mask, 20'hFFFFF};
		base_full  = {win_ff[sel].xlate_base, 10'h000};
		nxt_lookup.hit              = |win_hit;
		nxt_lookup.window           = sel;
		nxt_lookup.map_table_enable = win_ff[sel].map_table_enable;
		if (!win_ff[sel].map_table_enable)
			nxt_lookup.cpu_addr = (base_full & ~mask_full)
				| ({1'b0, lookup_addr} & mask_full);
		else if (|entry_match)
		begin
			nxt_lookup.entry_hit = 1'b1;
			for (int e = ENTRIES - 1; e >= 0; e--)
				if (entry_match[e])
					nxt_lookup.cpu_addr = {entry_ff[e].cpu_page,
						lookup_addr[addr_map_pkg::PAGE_OFFSET_W-1:0]};
		end
		else
		begin
			// miss: address of the map table entry to fetch
			page_index = ({1'b0, lookup_addr} & mask_full) >> addr_map_pkg::PAGE_OFFSET_W;
			nxt_lookup.cpu_addr = base_full
				+ (page_index << addr_map_pkg::MAP_ENTRY_SHIFT);
		end
		if (!nxt_lookup.hit)
			nxt_lookup = '0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			lookup_done_ff <= 1'b0;
			lookup_ff      <= '0;
		end
		else
		begin
			lookup_done_ff <= lookup_req;
			if (lookup_req)
				lookup_ff <= nxt_lookup;
		end
	end

endmodule // addr_map_regs

// file: rtl/addr_map_pkg.sv
/*
 * Shared constants and carriers for the bridge address-mapping register bank:
 * register offsets, field positions, reset values and the translation entry layout.
 * Assumes byte addresses on an 8-bit register port with 32-bit aligned words.
 */
package addr_map_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_WIN_BASE_1    = 8'h00;
	localparam logic [7:0] OFS_WIN_MASK_1    = 8'h04;
	localparam logic [7:0] OFS_XLATE_BASE_1  = 8'h08;
	localparam logic [7:0] OFS_WIN_BASE_2    = 8'h0C;
	localparam logic [7:0] OFS_WIN_MASK_2    = 8'h10;
	localparam logic [7:0] OFS_XLATE_BASE_2  = 8'h14;
	localparam logic [7:0] OFS_EXT_ZERO      = 8'h18;
	localparam logic [7:0] OFS_MEM_UPPER     = 8'h1C;
	localparam logic [7:0] OFS_IO_CFG_EXT    = 8'h20;
	localparam logic [7:0] OFS_LAT_PRELOAD   = 8'h24;
	localparam logic [7:0] OFS_FLUSH_ALL     = 8'h28;
	localparam logic [2:0] OFS_TAG_GROUP     = 3'h2;  // 0x40..0x5C
	localparam logic [2:0] OFS_PAGE_GROUP    = 3'h3;  // 0x60..0x7C

	// field positions
	localparam int unsigned WIN_FIELD_LSB    = 20;
	localparam int unsigned WIN_ENABLE_BIT   = 19;
	localparam int unsigned MAP_TABLE_BIT    = 18;
	localparam int unsigned XLATE_BASE_LSB   = 9;
	localparam int unsigned MEM_UPPER_LSB    = 27;
	localparam int unsigned IO_UPPER_LSB     = 24;
	localparam int unsigned CFG_LOW_LSB      = 0;
	localparam int unsigned PRELOAD_LSB      = 0;
	localparam int unsigned TAG_PAGE_LSB     = 13;
	localparam int unsigned TAG_VALID_BIT    = 12;
	localparam int unsigned CPU_PAGE_LSB     = 1;
	localparam int unsigned PAGE_OFFSET_W    = 13;
	localparam int unsigned MAP_ENTRY_SHIFT  = 3;  // 8-byte map table entries

	// reset values
	localparam logic [4:0]  MEM_UPPER_RST    = 5'h00;
	localparam logic [7:0]  IO_UPPER_RST     = 8'h00;
	localparam logic [1:0]  CFG_LOW_RST      = 2'h0;
	localparam logic [7:0]  PRELOAD_RST      = 8'h00;
	localparam logic [11:0] WIN_FIELD_RST    = 12'h000;
	localparam logic [22:0] XLATE_BASE_RST   = 23'h000000;
	localparam logic        ENTRY_VALID_RST  = 1'b0;

	typedef struct packed {
		logic [18:0] upper_pci_page;   // pci address bits 31:13
		logic        entry_valid_flag;
		logic [19:0] cpu_page;         // cpu address bits 32:13
	} xlate_entry_t;

	typedef struct packed {
		logic [11:0] base;
		logic [11:0] mask;
		logic        enable;
		logic        map_table_enable;
		logic [22:0] xlate_base;       // cpu address bits 32:10
	} window_t;

	typedef struct packed {
		logic        hit;
		logic        window;           // 0: first window, 1: second
		logic        map_table_enable;
		logic        entry_hit;
		logic [32:0] cpu_addr;
	} lookup_result_t;

endpackage

// file: test/addr_map_regs_monitor.sv
/* checker for the address-mapping register bank ports
 * assumes bus strobes are one cycle and never together */
`timescale 1ns/1ps
module addr_map_regs_monitor (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [4:0]  upper_pci_addr_bits,
	input wire logic [7:0]  io_upper_addr_bits,
	input wire logic [1:0]  cfg_low_addr_bits,
	input wire logic        master_start,
	input wire logic [7:0]  latency_count,
	input wire logic        latency_expired,
	input wire logic        fill_req,
	input wire logic        lookup_req,
	input wire logic        lookup_done
);
	logic [7:0] pre_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk)
	begin
		if (!resetn)
			pre_ff <= 8'h00;
		else if (reg_wr && reg_addr == 8'h24)
			pre_ff <= reg_wdata[7:0];
	end
	sequence s_flush; reg_wr && reg_addr == 8'h28 && !fill_req; endsequence
	sequence s_tag_rd; reg_rd && reg_addr[7:5] == 3'h2 && !fill_req; endsequence
	property p_flush; s_flush ##1 !fill_req ##1 s_tag_rd |=> !reg_rdata[12]; endproperty
	a_flush: assert property (p_flush) else $error("entry valid after flush");
	property p_ext_zero; reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0; endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("zero reg read");
	property p_mem_wr; reg_wr && reg_addr == 8'h1C
		|=> {upper_pci_addr_bits, 27'h0} == ($past(reg_wdata) & 32'hF8000000); endproperty
	a_mem_wr: assert property (p_mem_wr) else $error("memory upper bits");
	property p_mem_rd; reg_rd && reg_addr == 8'h1C
		|=> reg_rdata == {$past(upper_pci_addr_bits), 27'h0}; endproperty
	a_mem_rd: assert property (p_mem_rd) else $error("memory upper read");
	property p_io_wr; reg_wr && reg_addr == 8'h20 |=> {io_upper_addr_bits, 22'h0,
		cfg_low_addr_bits} == ($past(reg_wdata) & 32'hFF000003); endproperty
	a_io_wr: assert property (p_io_wr) else $error("io or cfg bits");
	property p_io_rd; reg_rd && reg_addr == 8'h20 |=> reg_rdata ==
		{$past(io_upper_addr_bits), 22'h0, $past(cfg_low_addr_bits)}; endproperty
	a_io_rd: assert property (p_io_rd) else $error("io cfg read");
	property p_preload; master_start |=> latency_count == $past(pre_ff) && !latency_expired;
	endproperty
	a_preload: assert property (p_preload) else $error("timer preload");
	property p_expired; latency_expired |-> latency_count == 8'h00; endproperty
	a_expired: assert property (p_expired) else $error("early expiry");
	property p_lookup; 1'b1 |=> lookup_done == $past(lookup_req); endproperty
	a_lookup: assert property (p_lookup) else $error("lookup done timing");
endmodule // addr_map_regs_monitor

bind addr_map_regs addr_map_regs_monitor mon_u (.clk, .resetn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .upper_pci_addr_bits, .io_upper_addr_bits,
	.cfg_low_addr_bits, .master_start, .latency_count, .latency_expired, .fill_req,
	.lookup_req, .lookup_done);

// file: test/addr_map_far.sv
/* far-side model: bus master start/active and entry fills
 * assumes callers enter just after a clock edge */
`timescale 1ns/1ps
module addr_map_far (
	input wire logic             clk,
	output logic                 master_start,
	output logic                 master_active,
	output logic                 fill_req,
	output logic [2:0]           fill_index,
	output addr_map_pkg::xlate_entry_t fill_entry
);
	initial
	begin
		master_start = 1'b0;
		master_active = 1'b0;
		fill_req = 1'b0;
		fill_index = 3'h0;
		fill_entry = '0;
	end
	task automatic run(input int n);
		@(posedge clk);
		master_start <= 1'b1;
		@(posedge clk);
		master_start <= 1'b0;
		master_active <= 1'b1;
		repeat (n) @(posedge clk);
		master_active <= 1'b0;
	endtask
	task automatic fill(input logic [2:0] i, input addr_map_pkg::xlate_entry_t e);
		@(posedge clk);
		fill_req <= 1'b1;
		fill_index <= i;
		fill_entry <= e;
		@(posedge clk);
		fill_req <= 1'b0;
		// released lines flip so stale data cannot pass
		fill_index <= ~i;
		fill_entry <= ~e;
	endtask
endmodule // addr_map_far

// file: test/test_pci_bridge_addr_map_regs.sv
/* self-checking bench for the address-mapping register bank
 * assumes the far-side model and the bound checker */
`timescale 1ns/1ps
module test_pci_bridge_addr_map_regs;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        lookup_req = 1'b0;
	logic [31:0] lookup_addr = 32'h0;
	logic [31:0] reg_rdata;
	logic [4:0]  upper_pci_addr_bits;
	logic [7:0]  io_upper_addr_bits, latency_count;
	logic [1:0]  cfg_low_addr_bits;
	logic [2:0]  fill_index;
	logic        master_start, master_active, fill_req, latency_expired, lookup_done;
	addr_map_pkg::xlate_entry_t   fill_entry;
	addr_map_pkg::lookup_result_t lookup_result;
	int          n_mismatch = 0;
	int          checks = 0;

	always #20 clk = ~clk;

	addr_map_regs dut_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.upper_pci_addr_bits, .io_upper_addr_bits, .cfg_low_addr_bits, .master_start,
		.master_active, .latency_count, .latency_expired, .fill_req, .fill_index,
		.fill_entry, .lookup_req, .lookup_addr, .lookup_done, .lookup_result);
	addr_map_far far_u (.clk, .master_start, .master_active, .fill_req, .fill_index,
		.fill_entry);

	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), reg_rdata, exp);
	endtask
	task automatic look(input logic [31:0] a, input logic [36:0] exp);
		@(posedge clk);
		lookup_req <= 1'b1;
		lookup_addr <= a;
		@(posedge clk);
		lookup_req <= 1'b0;
		#1 chk("lookup_done", lookup_done, 1'b1);
		chk("lookup_result", lookup_result, exp);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic t_regs;
		rc(8'h20, 32'h0);
		rc(8'h24, 32'h0);
		rc(8'h40, 32'h0);
		wr(8'h18, 32'hFFFFFFFF);
		rc(8'h18, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF);
		// the write lands in this time step; look once the flop has settled
		#1 chk("upper_pci_addr_bits", upper_pci_addr_bits, 5'h1F);
		rc(8'h1C, 32'hF8000000);
		wr(8'h20, 32'hFFFFFFFF);
		rc(8'h20, 32'hFF000003);
		wr(8'h20, 32'h5A000001);
		#1 chk("io_cfg", {io_upper_addr_bits, cfg_low_addr_bits}, 10'h169);
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h04 + 8'(i * 12), 32'hFFFFFFFF);
			rc(8'h04 + 8'(i * 12), 32'hFFF00000);
		end
		$display("register test done");
	endtask
	task automatic t_timer;
		wr(8'h24, 32'h00000003);
		far_u.run(3);
		#1 chk("latency_count", latency_count, 8'h00);
		chk("latency_expired", latency_expired, 1'b1);
		$display("timer test done");
	endtask
	task automatic t_entries;
		far_u.fill(3'h5, {19'h5A5A5, 1'b1, 20'hC3C3C});
		rc(8'h54, {19'h5A5A5, 1'b1, 12'h000});
		rc(8'h74, {11'h000, 20'hC3C3C, 1'b0});
		wr(8'h28, 32'h0);
		rc(8'h54, {19'h5A5A5, 13'h0000});
		$display("entry test done");
	endtask
	task automatic t_lookup;
		wr(8'h00, 32'h12380000);
		wr(8'h04, 32'h00100000);
		wr(8'h08, 32'h04000000);
		look(32'h12354321, {4'h8, 33'h008154321});
		look(32'h20000000, 37'h0);
		// table mode: an entry hit, then a miss that points into the map table
		wr(8'h00, 32'h123C0000);
		far_u.fill(3'h3, {19'h091AA, 1'b1, 20'hABCDE});
		look(32'h12354321, {4'hB, 33'h1579BC321});
		look(32'h12300000, {4'hA, 33'h008000400});
		$display("lookup test done");
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_regs;
		t_timer;
		t_entries;
		t_lookup;
		end_sim;
	end
	initial
	begin
		// generous span against a hung handshake
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end
endmodule // test_pci_bridge_addr_map_regs
